// ### shared/slc_pkg.sv
// Shared constants for the serial link control registers and their controller
package slc_pkg;
	localparam int              ADDR_W          = 12;
	localparam int              DATA_W          = 8;
	// Device register offsets
	localparam logic [11:0]     OFS_LINK_EN     = 12'h200;
	localparam logic [11:0]     OFS_MODE        = 12'h201;
	localparam logic [11:0]     OFS_KM1         = 12'h202;
	localparam logic [11:0]     OFS_RESYNC      = 12'h203;
	localparam logic [11:0]     OFS_CTRL        = 12'h204;
	// Device reset values
	localparam logic [7:0]      RST_LINK_EN     = 8'h01;
	localparam logic [7:0]      RST_MODE        = 8'h02;
	localparam logic [7:0]      RST_KM1         = 8'h1F;
	localparam logic [7:0]      RST_RESYNC      = 8'h01;
	localparam logic [7:0]      RST_CTRL        = 8'h03;
	// Link control fields
	localparam int              CTRL_W          = 5;
	localparam int              BIT_WHITEN      = 0;
	localparam int              BIT_FORMAT      = 1;
	localparam int              BIT_SEL_LO      = 2;
	localparam int              BIT_UPPER       = 4;
	localparam logic [1:0]      SEL_SE_PIN      = 2'h0;
	localparam logic [1:0]      SEL_TS_PIN      = 2'h1;
	localparam logic [1:0]      SEL_NO_PIN      = 2'h2;
	// Mode handling: modes at or above this code use 64b/66b
	localparam logic [7:0]      MODE_66B_FIRST  = 8'h10;
	localparam logic [7:0]      LOCKED_MODE_MAX = 8'h07;
	localparam logic [8:0]      K66_NUMER       = 9'h100;
	localparam logic [7:0]      ZERO8           = 8'h00;
	localparam logic [7:0]      ONE8            = 8'h01;
	// Controller APB map
	localparam logic [7:0]      CTL_CMD         = 8'h00;
	localparam logic [7:0]      CTL_STATUS      = 8'h04;
	localparam logic [7:0]      CTL_CAL         = 8'h08;
	localparam int              CMD_WRITE_BIT   = 31;
	localparam int              CMD_ADDR_LO     = 16;
	localparam int              ST_BUSY_BIT     = 0;
	localparam int              ST_REFUSED_BIT  = 1;
	localparam int              ST_RDATA_LO     = 8;
	typedef enum logic [1:0] {
		CTL_IDLE = 2'b01,
		CTL_WAIT = 2'b10
	} slc_ctl_state_t;
endpackage

// ### shared/slc_link_if.sv
// Register port between the controller and the link control register bank
`timescale 1ns/1ps
interface slc_link_if;
	logic                       req;
	logic                       we;
	logic [slc_pkg::ADDR_W-1:0] addr;
	logic [slc_pkg::DATA_W-1:0] wdata;
	logic [slc_pkg::DATA_W-1:0] rdata;
	logic                       ack;
	logic                       cal_en;
	modport dev (
		input  req,
		input  we,
		input  addr,
		input  wdata,
		input  cal_en,
		output rdata,
		output ack
	);
	modport ctl (
		output req,
		output we,
		output addr,
		output wdata,
		output cal_en,
		input  rdata,
		input  ack
	);
endinterface

// ### design/slc_link_dev.sv
// Serial link control register bank with link reset, lane and resync control
// Function
// - Link enable bit 0 resets 1, upper bits reserved
// - Disabled link: logic reset, serializers down, clocks gated
// - Disabled link clears frame counter; sysref ignored
// - Host clears link enable before other changes
// - Calibration on before link; link off first
// - Eight-bit link mode register resets to two
// - Mode changed only with link and calibration off
// - Mode lock restricts accepted link mode values
// - Multiframe length holds K minus one, reset 31
// - 64b/66b modes derive K from the mode
// - Multiframe length changed only while link off
// - Writing resync bit zero requests synchronisation
// - Software resync combines with any selected pin
// - Pin selection two releases a stuck pin
// - Link control resets to three, four fields
// - Pin select: single-ended, timestamp, or none
// - Format bit: one two's complement, zero offset
// - Whitening bit for 8b/10b; 66b always whitens
// - Upper mapping uses lanes 4-7, powers down 0-3
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
module slc_link_dev (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	slc_link_if.dev          lnk,
	input  wire logic        mode_lock,
	input  wire logic        sysref,
	input  wire logic        single_ended_resync_input,
	input  wire logic        timestamp_pin,
	output logic             link_reset_n,
	output logic             serializer_pd,
	output logic             link_clk_en,
	output logic [7:0]       lane_pd,
	output logic             sample_number_format,
	output logic             whitening_enable,
	output logic [7:0]       eff_k_minus_one,
	output logic [7:0]       lmfc_count,
	output logic             sync_request_n
);
	import slc_pkg::*;

	logic                    en_ff;
	logic                    nxt_en;
	logic [7:0]              mode_ff;
	logic [7:0]              nxt_mode;
	logic [7:0]              km1_ff;
	logic [7:0]              nxt_km1;
	logic                    rsync_ff;
	logic                    nxt_rsync;
	logic [CTRL_W-1:0]       ctrl_ff;
	logic [CTRL_W-1:0]       nxt_ctrl;
	logic                    ack_ff;
	logic                    nxt_ack;
	logic [7:0]              rdata_ff;
	logic [7:0]              nxt_rdata;
	logic                    wr;
	logic                    mode_ok;
	logic                    is_66b;
	logic [8:0]              k66;
	logic [7:0]              k_lim;
	logic                    pin_n;
	logic [1:0]              sel;

	// Register file and bus answer
	always_comb begin
		wr        = lnk.req & lnk.we;
		// Locked parts refuse the higher mode codes silently
		mode_ok   = ~mode_lock | (lnk.wdata <= LOCKED_MODE_MAX);
		nxt_en    = en_ff;
		nxt_mode  = mode_ff;
		nxt_km1   = km1_ff;
		nxt_rsync = rsync_ff;
		nxt_ctrl  = ctrl_ff;
		nxt_ack   = lnk.req;
		nxt_rdata = rdata_ff;
		if (wr) begin
			unique case (lnk.addr)
				OFS_LINK_EN: nxt_en = lnk.wdata[0];
				OFS_MODE: begin
					if (mode_ok) begin
						nxt_mode = lnk.wdata;
					end
				end
				OFS_KM1:     nxt_km1 = lnk.wdata;
				OFS_RESYNC:  nxt_rsync = lnk.wdata[0];
				OFS_CTRL:    nxt_ctrl = lnk.wdata[CTRL_W-1:0];
				default: begin
				end
			endcase
		end
		if (lnk.req & ~lnk.we) begin
			unique case (lnk.addr)
				OFS_LINK_EN: nxt_rdata = {7'h00, en_ff};
				OFS_MODE:    nxt_rdata = mode_ff;
				OFS_KM1:     nxt_rdata = km1_ff;
				OFS_RESYNC:  nxt_rdata = {7'h00, rsync_ff};
				OFS_CTRL:    nxt_rdata = {3'h0, ctrl_ff};
				default:     nxt_rdata = ZERO8;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_ff    <= RST_LINK_EN[0];
			mode_ff  <= RST_MODE;
			km1_ff   <= RST_KM1;
			rsync_ff <= RST_RESYNC[0];
			ctrl_ff  <= RST_CTRL[CTRL_W-1:0];
			ack_ff   <= 1'b0;
			rdata_ff <= ZERO8;
		end else if (ce) begin
			en_ff    <= nxt_en;
			mode_ff  <= nxt_mode;
			km1_ff   <= nxt_km1;
			rsync_ff <= nxt_rsync;
			ctrl_ff  <= nxt_ctrl;
			ack_ff   <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end

	assign lnk.ack   = ack_ff;
	assign lnk.rdata = rdata_ff;

	// Link side controls, all registered
	logic                    nxt_rst_n;
	logic                    nxt_pd;
	logic                    nxt_clk_en;
	logic [7:0]              nxt_lane_pd;
	logic                    nxt_fmt;
	logic                    nxt_whiten;
	logic [7:0]              nxt_effk;
	logic [7:0]              nxt_lmfc;
	logic                    nxt_sync_n;

	always_comb begin
		sel    = ctrl_ff[BIT_SEL_LO +: 2];
		is_66b = mode_ff >= MODE_66B_FIRST;
		// Fixed E of one; F taken from the two low mode bits
		k66    = K66_NUMER >> mode_ff[1:0];
		k_lim  = is_66b ? 8'(k66 - 9'h001) : km1_ff;
		unique case (sel)
			SEL_SE_PIN: pin_n = single_ended_resync_input;
			SEL_TS_PIN: pin_n = timestamp_pin;
			default:    pin_n = 1'b1;
		endcase
		nxt_sync_n  = rsync_ff & pin_n;
		nxt_rst_n   = en_ff;
		nxt_pd      = ~en_ff;
		nxt_clk_en  = en_ff;
		if (!en_ff) begin
			nxt_lane_pd = 8'hFF;
		end else if (ctrl_ff[BIT_UPPER]) begin
			nxt_lane_pd = 8'h0F;
		end else begin
			nxt_lane_pd = 8'hF0;
		end
		nxt_fmt     = ctrl_ff[BIT_FORMAT];
		nxt_whiten  = is_66b | ctrl_ff[BIT_WHITEN];
		nxt_effk    = k_lim;
		// Sysref can only align the counter once the link runs
		if (!en_ff) begin
			nxt_lmfc = ZERO8;
		end else if (sysref || lmfc_count >= k_lim) begin
			nxt_lmfc = ZERO8;
		end else begin
			nxt_lmfc = lmfc_count + ONE8;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_reset_n         <= 1'b0;
			serializer_pd        <= 1'b1;
			link_clk_en          <= 1'b0;
			lane_pd              <= 8'hFF;
			sample_number_format <= RST_CTRL[BIT_FORMAT];
			whitening_enable     <= RST_CTRL[BIT_WHITEN];
			eff_k_minus_one      <= RST_KM1;
			lmfc_count           <= ZERO8;
			sync_request_n       <= 1'b1;
		end else if (ce) begin
			link_reset_n         <= nxt_rst_n;
			serializer_pd        <= nxt_pd;
			link_clk_en          <= nxt_clk_en;
			lane_pd              <= nxt_lane_pd;
			sample_number_format <= nxt_fmt;
			whitening_enable     <= nxt_whiten;
			eff_k_minus_one      <= nxt_effk;
			lmfc_count           <= nxt_lmfc;
			sync_request_n       <= nxt_sync_n;
		end
	end
endmodule

// ### design/slc_link_ctl.sv
// APB controller that issues link register accesses and keeps ordering safe
`timescale 1ns/1ps
module slc_link_ctl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	slc_link_if.ctl          lnk
);
	import slc_pkg::*;

	slc_ctl_state_t          st_ff;
	slc_ctl_state_t          nxt_st;
	logic                    req_ff;
	logic                    nxt_req;
	logic                    we_ff;
	logic                    nxt_we;
	logic [ADDR_W-1:0]       addr_ff;
	logic [ADDR_W-1:0]       nxt_addr;
	logic [7:0]              wdata_ff;
	logic [7:0]              nxt_wdata;
	logic [7:0]              rd_ff;
	logic [7:0]              nxt_rd;
	logic                    cal_ff;
	logic                    nxt_cal;
	logic                    shen_ff;
	logic                    nxt_shen;
	logic                    ref_ff;
	logic                    nxt_ref;
	logic                    pready_ff;
	logic                    nxt_pready;
	logic                    perr_ff;
	logic                    nxt_perr;
	logic [31:0]             prdata_ff;
	logic [31:0]             nxt_prdata;
	logic                    hit;
	logic                    mapped;
	logic                    c_wr;
	logic [ADDR_W-1:0]       c_addr;
	logic [7:0]              c_data;
	logic                    viol;

	always_comb begin
		hit    = psel & penable & pready_ff;
		mapped = (paddr == CTL_CMD) | (paddr == CTL_STATUS) | (paddr == CTL_CAL);
		c_wr   = pwdata[CMD_WRITE_BIT];
		c_addr = pwdata[CMD_ADDR_LO +: ADDR_W];
		c_data = pwdata[7:0];
		// Only writes are policed; reads never disturb the link
		viol   = c_wr & (
			((c_addr > OFS_LINK_EN) & (c_addr <= OFS_CTRL) & shen_ff) |
			((c_addr == OFS_LINK_EN) & c_data[0] & ~cal_ff) |
			((c_addr == OFS_MODE) & cal_ff));
		nxt_st     = st_ff;
		nxt_req    = 1'b0;
		nxt_we     = we_ff;
		nxt_addr   = addr_ff;
		nxt_wdata  = wdata_ff;
		nxt_rd     = rd_ff;
		nxt_cal    = cal_ff;
		nxt_shen   = shen_ff;
		nxt_ref    = ref_ff;
		nxt_pready = psel & ~penable;
		nxt_perr   = psel & ~penable & ~mapped;
		nxt_prdata = prdata_ff;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				CTL_STATUS: begin
					nxt_prdata                    = 32'h0000_0000;
					nxt_prdata[ST_BUSY_BIT]       = (st_ff == CTL_WAIT);
					nxt_prdata[ST_REFUSED_BIT]    = ref_ff;
					nxt_prdata[ST_RDATA_LO +: 8]  = rd_ff;
				end
				CTL_CAL:    nxt_prdata = {31'h0000_0000, cal_ff};
				default:    nxt_prdata = 32'h0000_0000;
			endcase
		end
		unique case (st_ff)
			CTL_IDLE: begin
			end
			CTL_WAIT: begin
				if (lnk.ack) begin
					nxt_rd = lnk.rdata;
					nxt_st = CTL_IDLE;
				end
			end
		endcase
		if (hit && pwrite && paddr == CTL_CMD) begin
			if (st_ff == CTL_WAIT || viol) begin
				nxt_ref = 1'b1;
			end else begin
				nxt_ref   = 1'b0;
				nxt_req   = 1'b1;
				nxt_we    = c_wr;
				nxt_addr  = c_addr;
				nxt_wdata = c_data;
				nxt_st    = CTL_WAIT;
				if (c_wr && c_addr == OFS_LINK_EN) begin
					nxt_shen = c_data[0];
				end
			end
		end
		if (hit && pwrite && paddr == CTL_CAL) begin
			// Calibration may not drop under a running link
			if (!pwdata[0] && shen_ff) begin
				nxt_ref = 1'b1;
			end else begin
				nxt_cal = pwdata[0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff     <= CTL_IDLE;
			req_ff    <= 1'b0;
			we_ff     <= 1'b0;
			addr_ff   <= '0;
			wdata_ff  <= ZERO8;
			rd_ff     <= ZERO8;
			cal_ff    <= 1'b0;
			shen_ff   <= RST_LINK_EN[0];
			ref_ff    <= 1'b0;
			pready_ff <= 1'b0;
			perr_ff   <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (ce) begin
			st_ff     <= nxt_st;
			req_ff    <= nxt_req;
			we_ff     <= nxt_we;
			addr_ff   <= nxt_addr;
			wdata_ff  <= nxt_wdata;
			rd_ff     <= nxt_rd;
			cal_ff    <= nxt_cal;
			shen_ff   <= nxt_shen;
			ref_ff    <= nxt_ref;
			pready_ff <= nxt_pready;
			perr_ff   <= nxt_perr;
			prdata_ff <= nxt_prdata;
		end
	end

	assign pready     = pready_ff;
	assign pslverr    = perr_ff;
	assign prdata     = prdata_ff;
	assign lnk.req    = req_ff;
	assign lnk.we     = we_ff;
	assign lnk.addr   = addr_ff;
	assign lnk.wdata  = wdata_ff;
	assign lnk.cal_en = cal_ff;
endmodule

// ### test/slc_link_monitor.sv
// Checker on the register port between controller and register bank
`timescale 1ns/1ps
module slc_link_monitor (
	input wire logic				pclk,
	input wire logic				presetn,
	input wire logic				req,
	input wire logic				we,
	input wire logic [slc_pkg::ADDR_W-1:0]	addr,
	input wire logic [slc_pkg::DATA_W-1:0]	wdata,
	input wire logic [slc_pkg::DATA_W-1:0]	rdata,
	input wire logic				ack,
	input wire logic				cal_en
);
	import slc_pkg::*;
	logic	en_ff;
	logic	nxt_en;
	// Link enable as seen on the port; refused writes never reach it
	always_comb begin
		nxt_en = en_ff;
		if (req && we && addr == OFS_LINK_EN)
			nxt_en = wdata[0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			en_ff <= 1'b1;
		else
			en_ff <= nxt_en;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ack_next_a: assert property (req |=> ack && !req)
		else $error("ack not one cycle after request");
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (ack |-> $past(req))
		else $error("ack without request");
	link_off_first_a: assert property (req && we && addr inside {[OFS_MODE:OFS_CTRL]} |-> !en_ff)
		else $error("config write while link on");
	cal_before_a: assert property (req && we && addr == OFS_LINK_EN && wdata[0] |-> cal_en)
		else $error("link on without calibration");
	link_off_cal_a: assert property ($fell(cal_en) |-> !en_ff)
		else $error("calibration off while link on");
	mode_idle_a: assert property (req && we && addr == OFS_MODE |-> !cal_en && !en_ff)
		else $error("mode write while busy");
	resv_zero_a: assert property (ack && !$past(we) && $past(addr) == OFS_RESYNC
		|-> rdata[7:1] == 7'h00)
		else $error("reserved bits read nonzero");
	unmapped_zero_a: assert property (ack && !$past(we)
		&& !($past(addr) inside {[OFS_LINK_EN:OFS_CTRL]}) |-> rdata == ZERO8)
		else $error("unmapped read nonzero");
	cover property (req && we && addr == OFS_LINK_EN && !wdata[0]);
	cover property (req && !we);
	cover property ($fell(cal_en));
endmodule

// ### test/testbench.sv
// Testbench joining controller and register bank over the link port
`timescale 1ns/1ps
module testbench;
	import slc_pkg::*;
	logic		pclk = 1'b0;
	logic		presetn = 1'b0;
	logic		psel = 1'b0;
	logic		penable = 1'b0;
	logic		pwrite = 1'b0;
	logic [7:0]	paddr = 8'h00;
	logic [31:0]	pwdata = 32'h0;
	logic		mode_lock = 1'b0;
	logic		sysref = 1'b0;
	logic		se_pin = 1'b1;
	logic		ts_pin = 1'b1;
	logic [31:0]	prdata;
	logic		pready;
	logic		pslverr;
	logic		rst_n_o, ser_pd, clk_en, fmt, whit, sync_n, err;
	logic [7:0]	lane_pd, eff_k, lmfc, m;
	logic [31:0]	rnd = 32'h454ED48E;
	logic [31:0]	rd;
	logic [31:0]	exp_q[$];
	logic [31:0]	msk_q[$];
	logic [7:0]	rv[6] = '{8'h01, 8'h02, 8'h1F, 8'h01, 8'h03, 8'h00};
	int		mismatches = 0;
	int		compares = 0;
	int		i;
	slc_link_if lnk ();
	slc_link_ctl u_slc_link_ctl (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lnk(lnk.ctl));
	slc_link_dev u_slc_link_dev (.pclk(pclk), .presetn(presetn), .ce(1'b1), .lnk(lnk.dev),
		.mode_lock(mode_lock), .sysref(sysref), .single_ended_resync_input(se_pin),
		.timestamp_pin(ts_pin), .link_reset_n(rst_n_o), .serializer_pd(ser_pd),
		.link_clk_en(clk_en), .lane_pd(lane_pd), .sample_number_format(fmt),
		.whitening_enable(whit), .eff_k_minus_one(eff_k), .lmfc_count(lmfc),
		.sync_request_n(sync_n));
	slc_link_monitor u_slc_link_monitor (.pclk(pclk), .presetn(presetn), .req(lnk.req),
		.we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack),
		.cal_en(lnk.cal_en));
	always #50 pclk = ~pclk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Answer taken at the rising edge that samples pready high, then released
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic st(input logic [31:0] e, input logic [31:0] mk);
		exp_q.push_back(e);
		msk_q.push_back(mk);
		apb(1'b0, CTL_STATUS, 32'h0);
	endtask
	task automatic dev(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic [7:0] e, input logic rf);
		apb(1'b1, CTL_CMD, {w, 3'h0, a, 8'h00, d});
		rd = 32'h1;
		for (int k = 0; k < 20 && rd[0] !== 1'b0; k++)
			apb(1'b0, CTL_STATUS, 32'h0);
		st({16'h0, e, 6'h0, rf, 1'b0}, w ? 32'h3 : 32'hFF03);
	endtask
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
			chk(prdata & msk_q.pop_front(), exp_q.pop_front());
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
	end
	// Far beyond the few hundred cycles the sequence needs
	initial begin
		#3000000;
		mismatches++;
		finish_test();
	end
	initial begin
		wait (presetn === 1'b1);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk(32'({rst_n_o, ser_pd, clk_en, fmt, whit, sync_n}), 32'h2F);
		chk(32'({lane_pd, eff_k}), 32'hF01F);
		for (i = 0; i < 6; i++)
			dev(1'b0, OFS_LINK_EN + 12'(i), 8'h00, rv[i], 1'b0);
		$display("reset values done");
		dev(1'b1, OFS_MODE, 8'h03, 8'h00, 1'b1);
		dev(1'b1, OFS_LINK_EN, 8'h00, 8'h00, 1'b0);
		sysref <= 1'b1;
		repeat (3) @(posedge pclk);
		sysref <= 1'b0;
		mode_lock <= 1'b1;
		@(negedge pclk);
		chk(32'({rst_n_o, ser_pd, clk_en, lane_pd, lmfc}), 32'h2FF00);
		dev(1'b1, OFS_MODE, 8'h10, 8'h00, 1'b0);
		dev(1'b0, OFS_MODE, 8'h00, 8'h02, 1'b0);
		dev(1'b1, OFS_MODE, 8'h07, 8'h00, 1'b0);
		dev(1'b0, OFS_MODE, 8'h00, 8'h07, 1'b0);
		mode_lock <= 1'b0;
		rnd = xs(rnd);
		dev(1'b1, OFS_KM1, rnd[7:0], 8'h00, 1'b0);
		dev(1'b0, OFS_KM1, 8'h00, rnd[7:0], 1'b0);
		dev(1'b1, OFS_RESYNC, rnd[15:8] | 8'h80, 8'h00, 1'b0);
		dev(1'b0, OFS_RESYNC, 8'h00, {7'h0, rnd[8]}, 1'b0);
		$display("disabled link done");
		for (i = 0; i < 12; i++) begin
			if (i % 4 == 0)
				dev(1'b1, OFS_CTRL, {4'h0, 2'(i / 4), 2'h3}, 8'h00, 1'b0);
			dev(1'b1, OFS_RESYNC, {7'h0, i[0]}, 8'h00, 1'b0);
			se_pin <= i[1];
			ts_pin <= !i[1];
			repeat (2) @(posedge pclk);
			@(negedge pclk);
			chk(32'(sync_n), 32'(i[0] & (i < 4 ? i[1] : i < 8 ? !i[1] : 1'b1)));
		end
		$display("resync done");
		dev(1'b1, OFS_CTRL, 8'hF8, 8'h00, 1'b0);
		dev(1'b0, OFS_CTRL, 8'h00, 8'h18, 1'b0);
		dev(1'b1, OFS_KM1, 8'h03, 8'h00, 1'b0);
		dev(1'b1, OFS_LINK_EN, 8'h01, 8'h00, 1'b1);
		apb(1'b1, CTL_CAL, 32'h1);
		dev(1'b1, OFS_MODE, 8'h11, 8'h00, 1'b1);
		dev(1'b1, OFS_LINK_EN, 8'h01, 8'h00, 1'b0);
		repeat (2) @(posedge pclk);
		sysref <= 1'b1;
		@(posedge pclk);
		sysref <= 1'b0;
		@(negedge pclk);
		chk(32'({rst_n_o, ser_pd, clk_en, lane_pd}), 32'h50F);
		chk(32'({fmt, whit, eff_k, lmfc}), 32'h00300);
		m = 8'h00;
		repeat (20) begin
			@(negedge pclk);
			if (lmfc > m)
				m = lmfc;
		end
		chk(32'(m), 32'h3);
		dev(1'b1, OFS_KM1, 8'h05, 8'h00, 1'b1);
		apb(1'b1, CTL_CAL, 32'h0);
		st(32'h2, 32'h3);
		apb(1'b0, 8'h0C, 32'h0);
		chk(32'(err), 32'h1);
		$display("enabled link done");
		dev(1'b1, OFS_LINK_EN, 8'h00, 8'h00, 1'b0);
		apb(1'b1, CTL_CAL, 32'h0);
		dev(1'b1, OFS_MODE, 8'h11, 8'h00, 1'b0);
		apb(1'b1, CTL_CAL, 32'h1);
		dev(1'b1, OFS_LINK_EN, 8'h01, 8'h00, 1'b0);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		chk(32'({whit, eff_k}), 32'h17F);
		$display("wide block mode done");
		finish_test();
	end
endmodule
